// ---- dv/gpc_pin_model.sv ----
// Pad side model: resolves the level seen on each pin
module gpc_pin_model (
  input wire logic pclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] pad_pulldown,
  input wire logic [7:0] ext_drv,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_q;
  initial float_q = 8'h55;
  // A floating pin flips each cycle, so no stale value passes for a level
  always @(posedge pclk) float_q <= ~float_q;
  // Own drive wins, then the outside driver, then the weak pulls
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      if (pin_oe[n]) pin_in[n] = pin_out[n];
      else if (ext_drv[n]) pin_in[n] = ext_val[n];
      else if (pad_pullup[n]) pin_in[n] = 1'b1;
      else if (pad_pulldown[n]) pin_in[n] = 1'b0;
      else pin_in[n] = float_q[n];
    end
  end
endmodule : gpc_pin_model

// ---- dv/gpc_port_tb.sv ----
// Self-checking bench of the pin config core over APB
module gpc_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpc_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, slv, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] periph_out = 8'h00, periph_oe = 8'h00;
  logic [7:0] ext_drv = 8'hFF, ext_val = 8'h00;
  logic [7:0] pin_in, pin_out, pin_oe, periph_in, pad_slew;
  logic [7:0] pad_pullup, pad_pulldown, pad_analog;
  logic [15:0] pad_drive, exp_drv;
  int error_cnt = 0, check_count = 0, i;

  always #4 pclk = ~pclk;

  gpc_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .periph_out(periph_out),
    .periph_oe(periph_oe), .periph_in(periph_in), .pad_pullup(pad_pullup),
    .pad_pulldown(pad_pulldown), .pad_analog(pad_analog),
    .pad_drive(pad_drive), .pad_slew(pad_slew), .irq(irq));
  gpc_pin_model u_pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown),
    .ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    check_count++;
    if (seen !== ex) begin
      $display("MISMATCH %s expected %h seen %h", nm, ex, seen);
      error_cnt++;
    end
  endtask : chk

  // One APB transfer; the request is held until pready is seen high, and the run fails and stops after 16 cycles without it
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask : apb

  // Readback goes through the index register
  task cfg(input logic [31:0] idx);
    apb(1'b1, 12'h00C, idx);
    apb(1'b0, 12'h010, 32'h0);
  endtask : cfg

  task rst;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : rst

  initial begin
    rst();
    for (int n = 0; n < 8; n++) begin
      cfg(n);
      chk("cfg_reset", rd, 32'h0);
    end
    chk("pad_drive_reset", pad_drive, 32'h0);
    chk("pin_oe_reset", pin_oe, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped_data", rd, 32'h0);
    chk("unmapped_err", slv, 32'h1);
    $display("test reset done");
    // Pins 0-3 driven, 4-7 read from outside; only pins 0,1 get a one
    ext_val <= 8'hA0;
    apb(1'b1, 12'h000, 32'h0F01);
    apb(1'b1, 12'h40C, 32'hFF);
    repeat (4) @(posedge pclk);
    chk("pin_out", pin_out, 8'h03);
    chk("pin_oe", pin_oe, 8'h0F);
    apb(1'b0, 12'h7FC, 32'h0);
    chk("data_all", rd, 32'hA3);
    apb(1'b0, 12'h604, 32'h0);
    chk("data_sel", rd, 32'h81);
    $display("test data done");
    // Second reset in mid-run, then direction codes on pins 4 to 6
    ext_val <= 8'h00;
    rst();
    for (int d = 0; d < 3; d++)
      apb(1'b1, 12'h000, {16'h0, 8'h10 << d, 8'(d)});
    for (int d = 0; d < 3; d++) begin
      cfg(4 + d);
      chk("dir", rd[5:4], d);
    end
    cfg(7);
    chk("dir_keep", rd[5:4], 32'h0);
    periph_oe <= 8'h40;
    periph_out <= 8'h40;
    repeat (3) @(posedge pclk);
    chk("pin_oe_dir", pin_oe, 8'h60);
    chk("pin_out_periph", pin_out[6], 32'h1);
    $display("test direction done");
    // Every trigger code, one pin each; all written before any readback
    for (int t = 0; t < 5; t++)
      apb(1'b1, 12'h004, {16'h0, 8'h01 << t, 8'(t)});
    for (int t = 0; t < 5; t++) begin
      cfg(t);
      chk("trig", rd[10:8], t);
    end
    $display("test trigger done");
    exp_drv = 16'h0;
    for (int p = 0; p < 7; p++)
      apb(1'b1, 12'h008, {16'h0, 8'h01 << p, 2'b00, 2'(p % 4), 1'b0, 3'(p)});
    for (int p = 0; p < 7; p++) begin
      cfg(p);
      chk("pad", {rd[7:6], rd[2:0]}, {2'(p % 4), 3'(p)});
      exp_drv[2 * p +: 2] = 2'(p % 4);
    end
    chk("pad_drive", pad_drive, exp_drv);
    chk("pad_slew", pad_slew, 8'h08);
    chk("pad_pullup", pad_pullup, 8'h12);
    chk("pad_pulldown", pad_pulldown, 8'h24);
    chk("pad_analog", pad_analog, 8'h40);
    // Inputs 1 and 2 left undriven: only their pulls decide the level
    ext_drv <= 8'hF9;
    repeat (4) @(posedge pclk);
    apb(1'b0, 12'h418, 32'h0);
    chk("pull_level", rd, 32'h02);
    $display("test pad done");
    // Pin 7 held low while its trigger changes to rising
    apb(1'b1, 12'h004, 32'h8001);
    apb(1'b0, 12'h018, 32'h0);
    apb(1'b1, 12'h01C, 32'h80);
    chk("irq_idle", irq, 32'h0);
    ext_val <= 8'h80;
    i = 0;
    while (irq !== 1'b1 && i < 10) begin
      @(negedge pclk);
      i++;
    end
    chk("irq_rise", irq, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    chk("stat", rd[7:0] & 8'h80, 32'h80);
    repeat (2) @(negedge pclk);
    chk("irq_clear", irq, 32'h0);
    // Masked event still sets the sticky bit but keeps irq low
    apb(1'b1, 12'h01C, 32'h0);
    ext_val <= 8'h00;
    repeat (5) @(posedge pclk);
    ext_val <= 8'h80;
    repeat (6) @(negedge pclk);
    chk("irq_masked", irq, 32'h0);
    apb(1'b0, 12'h018, 32'h0);
    chk("stat_masked", rd[7:0] & 8'h80, 32'h80);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule : gpc_port_tb

// ---- hw/gpc_apb_slave.sv ----
// APB slave front end: decode only; the zero wait state answer comes from the top
`include "gpc_map.svh"
module gpc_apb_slave
  import gpc_pkg::*;
(
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  output logic wr_en,
  output logic rd_en,
  output logic data_win,
  output logic [11:0] reg_off
);
  // Access phase only; pready is tied high in the top, so one edge
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign data_win = (paddr & `GPC_DATA_WIN_MASK) == `GPC_OFF_DATA;
  assign reg_off = {paddr[11:2], 2'b00};
endmodule : gpc_apb_slave

// ---- hw/gpc_pin_detect.sv ----
// One pin: input synchroniser and trigger detector
`include "gpc_map.svh"
module gpc_pin_detect
  import gpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_raw,
  input wire logic [2:0] trig,
  output logic level,
  output logic event_hit
);
  logic meta_q;
  logic sync_q;
  logic prev_q;
  wire rise = sync_q & ~prev_q;
  wire fall = ~sync_q & prev_q;

  // Two flops before any detection; the first is read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;

  // Trigger selection per pin
  always_comb begin
    case (gpc_trig_type'(trig))
      GPC_TRIG_FALLING: event_hit = fall;
      GPC_TRIG_RISING: event_hit = rise;
      GPC_TRIG_BOTH: event_hit = rise | fall;
      GPC_TRIG_LOW: event_hit = ~sync_q;
      GPC_TRIG_HIGH: event_hit = sync_q;
      default: event_hit = 1'b0;
    endcase
  end
endmodule : gpc_pin_detect

// ---- hw/gpc_port.sv ----
// GPIO port pin configuration core with APB registers
`include "gpc_map.svh"
// Contract
// - Each pin is a software input, software output or peripheral pin.
// - Config writes carry an 8-bit mask, bit n selects pin n.
// - Software reads back one pin's direction by its index 0 to 7.
// - Each pin's trigger is falling, rising, both, low or high.
// - Software reads back one pin's trigger type by index.
// - Drive strength is 2 mA, 4 mA, 8 mA or 8 mA slew limited.
// - Pad type is one of seven push-pull, open-drain or analog kinds.
// - Pad settings of inputs are stored; the pull, analog, drive and slew outputs all follow them.
// - Software reads back drive and pad type of any pin, inputs too.
// - Reset leaves pins as software inputs, no pull, push-pull, GPIO.
// - Reset leaves drive strength at the 2 mA setting.
// - Data accesses use address bits as a per-pin mask.
// - Masked data reads return pin levels, zero where unselected.
module gpc_port
  import gpc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic [7:0] periph_out,
  input wire logic [7:0] periph_oe,
  output logic [7:0] periph_in,
  output logic [7:0] pad_pullup,
  output logic [7:0] pad_pulldown,
  output logic [7:0] pad_analog,
  output logic [15:0] pad_drive,
  output logic [7:0] pad_slew,
  output logic irq
);
  logic [1:0] dir_q [8];
  logic [2:0] trig_q [8];
  logic [1:0] drv_q [8];
  logic [2:0] pad_q [8];
  logic [7:0] out_q;
  logic [7:0] stat_q;
  logic [7:0] mask_q;
  logic [2:0] idx_q;
  logic [31:0] prdata_q;
  logic [7:0] pin_out_q;
  logic [7:0] pin_oe_q;
  logic [7:0] pu_q;
  logic [7:0] pd_q;
  logic [7:0] an_q;
  logic [15:0] drive_q;
  logic [7:0] slew_q;
  logic irq_q;
  logic [7:0] lvl;
  logic [7:0] hit;
  logic wr_en;
  logic rd_en;
  logic data_win;
  logic [11:0] reg_off;

  // Pad type helpers used by several decoders
  function automatic logic pad_pulls_up(input logic [2:0] p);
    pad_pulls_up = (p == GPC_PAD_PUSH_PULL_PULLUP) ||
                   (p == GPC_PAD_OPEN_DRAIN_PULLUP);
  endfunction : pad_pulls_up

  function automatic logic pad_pulls_down(input logic [2:0] p);
    pad_pulls_down = (p == GPC_PAD_PUSH_PULL_PULLDOWN) ||
                     (p == GPC_PAD_OPEN_DRAIN_PULLDOWN);
  endfunction : pad_pulls_down

  function automatic logic pad_is_od(input logic [2:0] p);
    pad_is_od = (p == GPC_PAD_OPEN_DRAIN) ||
                (p == GPC_PAD_OPEN_DRAIN_PULLUP) ||
                (p == GPC_PAD_OPEN_DRAIN_PULLDOWN);
  endfunction : pad_is_od

  gpc_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .wr_en(wr_en),
    .rd_en(rd_en),
    .data_win(data_win),
    .reg_off(reg_off)
  );

  // Write strobes for each writable register, and the status read strobe
  wire wr_dir = wr_en & ~data_win & (reg_off == `GPC_OFF_DIR_SET);
  wire wr_trig = wr_en & ~data_win & (reg_off == `GPC_OFF_TRIG_SET);
  wire wr_pad = wr_en & ~data_win & (reg_off == `GPC_OFF_PAD_SET);
  wire wr_idx = wr_en & ~data_win & (reg_off == `GPC_OFF_INDEX);
  wire wr_out = wr_en & ~data_win & (reg_off == `GPC_OFF_OUT);
  wire wr_mask = wr_en & ~data_win & (reg_off == `GPC_OFF_IRQ_MASK);
  wire wr_data = wr_en & data_win;
  wire rd_stat = rd_en & ~data_win & (reg_off == `GPC_OFF_IRQ_STAT);
  wire [7:0] sel = pwdata[`GPC_SEL_LSB +: 8];
  wire [7:0] data_sel = paddr[9:2];
  wire mapped = data_win ||
    (reg_off == `GPC_OFF_DIR_SET) || (reg_off == `GPC_OFF_TRIG_SET) ||
    (reg_off == `GPC_OFF_PAD_SET) || (reg_off == `GPC_OFF_INDEX) ||
    (reg_off == `GPC_OFF_CFG_GET) || (reg_off == `GPC_OFF_OUT) ||
    (reg_off == `GPC_OFF_IRQ_STAT) || (reg_off == `GPC_OFF_IRQ_MASK);

  // Level seen at each pin: the synchronised pad input, for every direction
  wire [7:0] pin_level = lvl;

  // Read-back of the indexed pin's settings
  wire [31:0] cfg_word = {16'h0000, 5'h00,
    trig_q[idx_q], drv_q[idx_q], dir_q[idx_q], 1'b0, pad_q[idx_q]};

  // Read mux; unmapped offsets read zero and flag an error
  wire [31:0] rd_mux =
    data_win ? {24'h000000, pin_level & data_sel} :
    (reg_off == `GPC_OFF_CFG_GET) ? cfg_word :
    (reg_off == `GPC_OFF_INDEX) ? {29'h0, idx_q} :
    (reg_off == `GPC_OFF_OUT) ? {24'h000000, out_q} :
    (reg_off == `GPC_OFF_IRQ_STAT) ? {24'h000000, stat_q} :
    (reg_off == `GPC_OFF_IRQ_MASK) ? {24'h000000, mask_q} :
    32'h00000000;

  // Per-pin config storage and pin drivers
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      gpc_pin_detect u_det (
        .pclk(pclk),
        .presetn(presetn),
        .pin_raw(pin_in[g]),
        .trig(trig_q[g]),
        .level(lvl[g]),
        .event_hit(hit[g])
      );
      wire periph = dir_q[g] == GPC_DIR_PERIPHERAL;
      wire drv_val = periph ? periph_out[g] : out_q[g];
      wire drv_en = periph ? periph_oe[g] : (dir_q[g] == GPC_DIR_OUT);
      wire od = pad_is_od(pad_q[g]);
      wire analog = pad_q[g] == GPC_PAD_ANALOG;

      // Unselected pins keep every setting
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dir_q[g] <= `GPC_DIR_RESET;
          trig_q[g] <= `GPC_TRIG_RESET;
          drv_q[g] <= `GPC_DRV_RESET;
          pad_q[g] <= `GPC_PAD_RESET;
        end else begin
          if (wr_dir && sel[g]) begin
            dir_q[g] <= pwdata[1:0];
          end
          if (wr_trig && sel[g]) begin
            trig_q[g] <= pwdata[2:0];
          end
          if (wr_pad && sel[g]) begin
            drv_q[g] <= pwdata[`GPC_DRV_LSB +: 2];
            pad_q[g] <= pwdata[2:0];
          end
        end
      end

      // Pad outputs registered; open drain only ever drives low
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pin_out_q[g] <= 1'b0;
          pin_oe_q[g] <= 1'b0;
          pu_q[g] <= 1'b0;
          pd_q[g] <= 1'b0;
          an_q[g] <= 1'b0;
          drive_q[2*g +: 2] <= `GPC_DRV_RESET;
          slew_q[g] <= 1'b0;
        end else begin
          pin_out_q[g] <= od ? 1'b0 : drv_val;
          pin_oe_q[g] <= drv_en & ~analog & (od ? ~drv_val : 1'b1);
          pu_q[g] <= pad_pulls_up(pad_q[g]);
          pd_q[g] <= pad_pulls_down(pad_q[g]);
          an_q[g] <= analog;
          drive_q[2*g +: 2] <= drv_q[g];
          slew_q[g] <= drv_q[g] == GPC_DRIVE_STRONG_SLEWED;
        end
      end
    end
  endgenerate

  // Output data, mask, index and sticky status; a set beats a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 8'h00;
      mask_q <= 8'h00;
      idx_q <= 3'h0;
      stat_q <= 8'h00;
      prdata_q <= 32'h00000000;
      irq_q <= 1'b0;
    end else begin
      if (wr_out) out_q <= pwdata[7:0];
      if (wr_data) out_q <= (out_q & ~data_sel) |
                            (pwdata[7:0] & data_sel);
      if (wr_mask) mask_q <= pwdata[7:0];
      if (wr_idx) idx_q <= pwdata[`GPC_IDX_W-1:0];
      stat_q <= (rd_stat ? 8'h00 : stat_q) | hit;
      if (rd_en) prdata_q <= rd_mux;
      irq_q <= |(((rd_stat ? 8'h00 : stat_q) | hit) & mask_q);
    end
  end

  // Zero wait state answer; read data is combinational from the decode
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rd_en ? rd_mux : prdata_q;
  assign periph_in = lvl;
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pad_pullup = pu_q;
  assign pad_pulldown = pd_q;
  assign pad_analog = an_q;
  assign pad_drive = drive_q;
  assign pad_slew = slew_q;
  assign irq = irq_q;

  // Checks
  a_reset_dir: assert property (@(posedge pclk)
    $rose(presetn) |-> dir_q[0] == GPC_DIR_IN)
    else $error("pin 0 not an input after reset");
  a_reset_drive: assert property (@(posedge pclk)
    $rose(presetn) |-> drive_q == 16'h0000)
    else $error("drive not weak after reset");
  a_mask_keep: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_dir && !sel[3]) |=> $stable(dir_q[3]))
    else $error("unselected pin direction changed");
  a_mask_take: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_dir && sel[0]) |=> dir_q[0] == $past(pwdata[1:0]))
    else $error("selected pin missed direction write");
  a_data_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && data_win) |-> (prdata[7:0] & ~data_sel) == 8'h00)
    else $error("unselected data bit not zero");
  a_data_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_data && !data_sel[5]) |=> $stable(out_q[5]))
    else $error("masked data write hit unselected pin");
  a_edge_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    hit[1] |=> stat_q[1])
    else $error("pending bit not set by event");
  a_cfg_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !data_win && reg_off == `GPC_OFF_CFG_GET)
      |-> prdata[5:4] == dir_q[idx_q])
    else $error("direction readback wrong");
  a_trig_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !data_win && reg_off == `GPC_OFF_CFG_GET)
      |-> prdata[10:8] == trig_q[idx_q])
    else $error("trigger readback wrong");
  a_pad_read: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && !data_win && reg_off == `GPC_OFF_CFG_GET)
      |-> prdata[2:0] == pad_q[idx_q] && prdata[7:6] == drv_q[idx_q])
    else $error("pad readback wrong");
  a_od_high: assert property (@(posedge pclk) disable iff (!presetn)
    pad_is_od(pad_q[3]) |=> !pin_out[3])
    else $error("open drain pin drove high");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == $past(|(((rd_stat ? 8'h00 : stat_q) | hit) & mask_q)))
    else $error("irq does not follow masked status");
  c_dir_write: cover property (@(posedge pclk) wr_dir && sel == 8'h09);
  c_irq_rise: cover property (@(posedge pclk) $rose(irq));
  c_data_read: cover property (@(posedge pclk) rd_en && data_win);
  c_set_clear: cover property (@(posedge pclk) rd_stat && |hit);
endmodule : gpc_port

// ---- include/gpc_map.svh ----
// Register offsets, field encodings and reset values of the pin config core
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
`define GPC_OFF_DIR_SET 12'h000
`define GPC_OFF_TRIG_SET 12'h004
`define GPC_OFF_PAD_SET 12'h008
`define GPC_OFF_INDEX 12'h00C
`define GPC_OFF_CFG_GET 12'h010
`define GPC_OFF_OUT 12'h014
`define GPC_OFF_IRQ_STAT 12'h018
`define GPC_OFF_IRQ_MASK 12'h01C
`define GPC_OFF_DATA 12'h400
`define GPC_DATA_WIN_MASK 12'hC00
`define GPC_DIR_RESET 2'h0
`define GPC_TRIG_RESET 3'h0
`define GPC_DRV_RESET 2'h0
`define GPC_PAD_RESET 3'h0
`define GPC_SEL_LSB 8
`define GPC_VAL_LSB 0
`define GPC_DRV_LSB 4
`define GPC_TRIG_LSB 8
`define GPC_IDX_W 3
`endif

// ---- include/gpc_pkg.sv ----
// Types of the pin config core
package gpc_pkg;
  typedef enum logic [1:0] {
    GPC_DIR_IN = 2'h0,
    GPC_DIR_OUT = 2'h1,
    GPC_DIR_PERIPHERAL = 2'h2
  } gpc_dir_type;
  typedef enum logic [2:0] {
    GPC_TRIG_FALLING = 3'h0,
    GPC_TRIG_RISING = 3'h1,
    GPC_TRIG_BOTH = 3'h2,
    GPC_TRIG_LOW = 3'h3,
    GPC_TRIG_HIGH = 3'h4
  } gpc_trig_type;
  typedef enum logic [1:0] {
    GPC_DRIVE_WEAK = 2'h0,
    GPC_DRIVE_MEDIUM = 2'h1,
    GPC_DRIVE_STRONG = 2'h2,
    GPC_DRIVE_STRONG_SLEWED = 2'h3
  } gpc_drive_type;
  typedef enum logic [2:0] {
    GPC_PAD_PUSH_PULL = 3'h0,
    GPC_PAD_PUSH_PULL_PULLUP = 3'h1,
    GPC_PAD_PUSH_PULL_PULLDOWN = 3'h2,
    GPC_PAD_OPEN_DRAIN = 3'h3,
    GPC_PAD_OPEN_DRAIN_PULLUP = 3'h4,
    GPC_PAD_OPEN_DRAIN_PULLDOWN = 3'h5,
    GPC_PAD_ANALOG = 3'h6
  } gpc_pad_type;
endpackage : gpc_pkg
